// [rtl/abmp_pkg.sv]
// constants shared by the serial rate, mute and parity block
// assumes a 32-bit apb bus whose byte address sits in paddr[7:0]
package abmp_pkg;
  // --------------------------------------------------
  // register byte offsets
  // --------------------------------------------------
  localparam logic [7:0] OFS_STATUS  = 8'h00; // status_reg
  localparam logic [7:0] OFS_DATA    = 8'h04; // data buffer
  localparam logic [7:0] OFS_RATE    = 8'h08; // rate_select_reg
  localparam logic [7:0] OFS_CTL1    = 8'h0C; // control_one
  localparam logic [7:0] OFS_CTL2    = 8'h10; // control_two
  localparam logic [7:0] OFS_TX_FINE = 8'h14; // tx_fine_prescaler
  localparam logic [7:0] OFS_RX_FINE = 8'h18; // rx_fine_prescaler
  // --------------------------------------------------
  // reset values
  // --------------------------------------------------
  localparam logic [7:0] RST_STATUS  = 8'hC0; // tdre and tc set
  localparam logic [7:0] RST_ZERO    = 8'h00;
  // --------------------------------------------------
  // field positions
  // --------------------------------------------------
  localparam int RATE_PR_LO = 6; // common_prescale_sel [7:6]
  localparam int RATE_TX_LO = 3; // tx_pow2_div_sel [5:3]
  localparam int RATE_RX_LO = 0; // rx_pow2_div_sel [2:0]
  // control_one bits
  localparam int C1_R8 = 7;
  localparam int C1_T8 = 6;
  localparam int C1_M = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PCE = 2;
  localparam int C1_PS = 1;
  localparam int C1_PIE = 0;
  // control_two bits
  localparam int C2_TIE = 7;
  localparam int C2_TCIE = 6;
  localparam int C2_RIE = 5;
  localparam int C2_ILIE = 4;
  localparam int C2_TE = 3;
  localparam int C2_RE = 2;
  localparam int C2_RWU = 1;
  // --------------------------------------------------
  // rate and sampling counts
  // --------------------------------------------------
  localparam logic [3:0] PR_SEL0 = 4'h1;
  localparam logic [3:0] PR_SEL1 = 4'h3;
  localparam logic [3:0] PR_SEL2 = 4'h4;
  localparam logic [3:0] PR_SEL3 = 4'hD;
  localparam logic [4:0] SMP_EDGE1 = 5'h03; // edge check samples
  localparam logic [4:0] SMP_EDGE2 = 5'h05;
  localparam logic [4:0] SMP_EDGE3 = 5'h07;
  localparam logic [4:0] SMP_MID1 = 5'h08;  // majority samples
  localparam logic [4:0] SMP_MID2 = 5'h09;
  localparam logic [4:0] SMP_MID3 = 5'h0A;
  localparam logic [3:0] PH_LAST = 4'hF;    // 16th sample of a bit
  localparam logic [3:0] BITS_SHORT = 4'h8; // data bits, m = 0
  localparam logic [3:0] BITS_LONG = 4'h9;  // data bits, m = 1
  localparam logic [7:0] IDLE_SHORT = 8'hA0; // 10 bits x 16
  localparam logic [7:0] IDLE_LONG = 8'hB0;  // 11 bits x 16

  // receive sequencer states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } abmp_rx_t;
endpackage : abmp_pkg

// [rtl/abmp_serial.sv]
// serial rate generators, framing, parity, mute and noise logic
// assumes an apb master on pclk and a serial line synchronous to pclk
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps

module abmp_serial
  import abmp_pkg::*;
(
  input  wire logic        pclk,       // system clock
  input  wire logic        presetn,    // async reset, active low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error on unmapped
  input  wire logic        halt_mode,  // processor in halt
  input  wire logic        rxd,        // serial receive line
  output logic             txd,        // serial transmit line
  output logic             irq_req     // interrupt and wait wake
);

  // --------------------------------------------------
  // state record
  // --------------------------------------------------
  typedef struct packed {
    logic [7:0]  rate;     // rate_select_reg
    logic [7:0]  tx_fine;  // tx_fine_factor
    logic [7:0]  rx_fine;  // rx_fine_factor
    logic [7:0]  ctl1;     // control_one
    logic [7:0]  ctl2;     // control_two
    logic [7:0]  status;   // status_reg
    logic        sr_seen;  // status read armed a clear
    logic [7:0]  rdr;      // received data
    logic [7:0]  tdr;      // pending transmit data
    logic [7:0]  prd;      // registered read data
    logic [18:0] tx_cnt;   // tx 16x divider
    logic [18:0] rx_cnt;   // rx 16x divider
    logic        tx_busy;  // frame on the line
    logic [11:0] tx_sh;    // frame shifter, lsb on line
    logic [3:0]  tx_ph;    // tx sample phase
    logic [3:0]  tx_bit;   // bits sent
    logic [3:0]  tx_nb;    // data bits in frame
    abmp_rx_t    rx_st;    // receive sequencer
    logic [3:0]  rx_ph;    // rx sample phase
    logic [3:0]  rx_bit;   // data bits taken
    logic [2:0]  rx_hist;  // samples before edge
    logic [2:0]  rx_smp;   // samples 8,9,10
    logic [8:0]  rx_sh;    // receive shifter
    logic        rx_noise; // noise seen since the last accepted frame
    logic        rx_m;     // frame word length
    logic        rx_pce;   // frame parity enable
    logic        rx_ps;    // frame parity select
    logic [7:0]  idle_cnt; // high samples while idle
    logic        idle_arm; // idle flag may set again
  } abmp_state_t;

  abmp_state_t s_q;  // registered state
  abmp_state_t s_d;  // next state

  // status bit positions
  localparam int ST_TDRE = 7;
  localparam int ST_TC = 6;
  localparam int ST_RX_DATA_READY = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OR = 3;
  localparam int ST_NF = 2;
  localparam int ST_FE = 1;
  localparam int ST_PE = 0;

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  // clocks per 16x pulse: pr * 2^sel * fine
  function automatic logic [18:0] rate_div(
    input logic [1:0] pr_sel,
    input logic [2:0] p2_sel,
    input logic [7:0] fine
  );
    logic [18:0] pr;
    logic [18:0] f;
    case (pr_sel)
      2'd0:    pr = 19'(PR_SEL0);
      2'd1:    pr = 19'(PR_SEL1);
      2'd2:    pr = 19'(PR_SEL2);
      default: pr = 19'(PR_SEL3);
    endcase
    f = (fine == 8'h00) ? 19'h00001 : 19'(fine);
    rate_div = 19'((pr << p2_sel) * f);
  endfunction : rate_div

  // majority vote of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  // xor over the 7 or 8 bits below the msb of the word
  function automatic logic low_xor(input logic [8:0] w, input logic m);
    low_xor = m ? ^w[7:0] : ^w[6:0];
  endfunction : low_xor

  // --------------------------------------------------
  // rate pulses
  // --------------------------------------------------
  logic [18:0] tx_div;  // tx clocks per pulse
  logic [18:0] rx_div;  // rx clocks per pulse
  logic        tx_tick; // tx 16x pulse
  logic        rx_tick; // rx 16x pulse

  assign tx_div = rate_div(s_q.rate[RATE_PR_LO +: 2],
                           s_q.rate[RATE_TX_LO +: 3], s_q.tx_fine);
  assign rx_div = rate_div(s_q.rate[RATE_PR_LO +: 2],
                           s_q.rate[RATE_RX_LO +: 3], s_q.rx_fine);
  // compare with at-or-above so a smaller divide never strands the counter past its end
  assign tx_tick = (s_q.tx_cnt >= tx_div - 19'h00001);
  assign rx_tick = (s_q.rx_cnt >= rx_div - 19'h00001);

  // --------------------------------------------------
  // bus decode
  // --------------------------------------------------
  logic setup;  // apb setup phase
  logic access; // apb access phase
  logic mapped; // address hits a register

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == OFS_STATUS) || (paddr == OFS_DATA) ||
                  (paddr == OFS_RATE) || (paddr == OFS_CTL1) ||
                  (paddr == OFS_CTL2) || (paddr == OFS_TX_FINE) ||
                  (paddr == OFS_RX_FINE);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = {24'h000000, s_q.prd};
  assign txd = s_q.tx_sh[0];

  // enabled events request an interrupt, which also ends wait
  assign irq_req = (s_q.ctl2[C2_TIE] & s_q.status[ST_TDRE]) |
                   (s_q.ctl2[C2_TCIE] & s_q.status[ST_TC]) |
                   (s_q.ctl2[C2_RIE] & (s_q.status[ST_RX_DATA_READY] |
                                        s_q.status[ST_OR])) |
                   (s_q.ctl2[C2_ILIE] & s_q.status[ST_IDLE]) |
                   (s_q.ctl1[C1_PIE] & s_q.status[ST_PE]);

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    logic [4:0] snum;  // sample number 2..17, 17 standing for sample 1
    logic [8:0] word;  // received word, lsb aligned
    logic [8:0] txw;   // word to transmit
    logic       msb;   // received data msb
    logic       bitv;  // voted bit value
    logic       wr2;   // control_two written now
    s_d = s_q;
    snum = 5'h00;
    word = 9'h000;
    txw = 9'h000;
    msb = 1'b0;
    bitv = 1'b0;
    wr2 = 1'b0;
    // read mux captured in setup so data leaves a flop
    if (setup && !pwrite) begin
      case (paddr)
        OFS_STATUS:  s_d.prd = s_q.status;
        OFS_DATA:    s_d.prd = s_q.rdr;
        OFS_RATE:    s_d.prd = s_q.rate;
        OFS_CTL1:    s_d.prd = s_q.ctl1;
        OFS_CTL2:    s_d.prd = s_q.ctl2;
        OFS_TX_FINE: s_d.prd = s_q.tx_fine;
        OFS_RX_FINE: s_d.prd = s_q.rx_fine;
        default:     s_d.prd = RST_ZERO;
      endcase
    end
    // halt freezes every register, both engines included, except the read data register
    if (!halt_mode) begin
      // ---- software side: clears first, so hardware sets win
      if (access && !pwrite) begin
        if (paddr == OFS_STATUS) begin
          s_d.sr_seen = 1'b1;
        end else if (paddr == OFS_DATA && s_q.sr_seen) begin
          s_d.sr_seen = 1'b0;
          s_d.status[5:0] = 6'h00; // receive side flags
        end
      end
      if (access && pwrite) begin
        case (paddr)
          OFS_DATA: begin
            s_d.tdr = pwdata[7:0];
            s_d.status[ST_TDRE] = 1'b0;
            if (s_q.sr_seen) begin
              s_d.status[ST_TC] = 1'b0;
              s_d.sr_seen = 1'b0;
            end
          end
          OFS_RATE:    s_d.rate = pwdata[7:0];
          OFS_TX_FINE: s_d.tx_fine = pwdata[7:0];
          OFS_RX_FINE: s_d.rx_fine = pwdata[7:0];
          OFS_CTL1: begin
            s_d.ctl1 = {s_q.ctl1[C1_R8], pwdata[6], 1'b0, pwdata[4:0]};
          end
          OFS_CTL2: begin
            s_d.ctl2 = {pwdata[7:1], 1'b0};
            wr2 = 1'b1; // written mute value beats a wake
          end
          default: ;
        endcase
      end
      // ---- transmit side
      s_d.tx_cnt = tx_tick ? 19'h00000 : s_q.tx_cnt + 19'h00001;
      if (!s_q.tx_busy && s_q.ctl2[C2_TE] && !s_q.status[ST_TDRE]) begin
        // load frame: start, data, stop; format fixed per frame
        txw = {s_q.ctl1[C1_M] ? s_q.ctl1[C1_T8] : 1'b1, s_q.tdr};
        if (s_q.ctl1[C1_PCE]) begin
          if (s_q.ctl1[C1_M]) begin
            txw[8] = low_xor(txw, 1'b1) ^ s_q.ctl1[C1_PS];
          end else begin
            txw[7] = low_xor(txw, 1'b0) ^ s_q.ctl1[C1_PS];
          end
        end
        s_d.tx_sh = {2'b11, txw, 1'b0};
        s_d.tx_nb = s_q.ctl1[C1_M] ? BITS_LONG : BITS_SHORT;
        s_d.tx_busy = 1'b1;
        s_d.tx_ph = 4'h0;
        s_d.tx_bit = 4'h0;
        s_d.status[ST_TDRE] = 1'b1;
      end else if (s_q.tx_busy && tx_tick) begin
        s_d.tx_ph = s_q.tx_ph + 4'h1;
        if (s_q.tx_ph == PH_LAST) begin
          s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
          s_d.tx_bit = s_q.tx_bit + 4'h1;
          // start + data + stop sent
          if (s_q.tx_bit == s_q.tx_nb + 4'h1) begin
            s_d.tx_busy = 1'b0;
            s_d.status[ST_TC] = 1'b1;
          end
        end
      end
      // ---- receive side
      s_d.rx_cnt = rx_tick ? 19'h00000 : s_q.rx_cnt + 19'h00001;
      if (!s_q.ctl2[C2_RE]) begin
        s_d.rx_st = RX_IDLE;
        s_d.rx_hist = 3'b000;
      end else if (rx_tick) begin
        s_d.rx_ph = s_q.rx_ph + 4'h1;
        snum = 5'(s_q.rx_ph) + 5'h02;
        if (snum == SMP_MID1) s_d.rx_smp[0] = rxd;
        if (snum == SMP_MID2) s_d.rx_smp[1] = rxd;
        if (snum == SMP_MID3) s_d.rx_smp[2] = rxd;
        bitv = maj3({rxd, s_q.rx_smp[1:0]});
        case (s_q.rx_st)
          RX_IDLE: begin
            s_d.rx_hist = {s_q.rx_hist[1:0], rxd};
            if (!rxd) begin
              // falling edge: realign phase to sample 1
              s_d.rx_st = RX_START;
              s_d.rx_ph = 4'h0;
              s_d.idle_cnt = 8'h00;
              s_d.rx_m = s_q.ctl1[C1_M];
              s_d.rx_pce = s_q.ctl1[C1_PCE];
              s_d.rx_ps = s_q.ctl1[C1_PS];
              s_d.rx_sh = 9'h000;
              s_d.rx_bit = 4'h0;
              if (s_q.rx_hist != 3'b111) s_d.rx_noise = 1'b1;
            end else if (s_q.idle_cnt !=
                         (s_q.ctl1[C1_M] ? IDLE_LONG : IDLE_SHORT)) begin
              s_d.idle_cnt = s_q.idle_cnt + 8'h01;
            end else begin
              // a whole idle frame seen, once per count
              s_d.idle_cnt = 8'h00;
              if (s_q.ctl2[C2_RWU]) begin
                if (!s_q.ctl1[C1_WAKE] && !wr2) begin
                  s_d.ctl2[C2_RWU] = 1'b0;
                end
              end else if (s_q.idle_arm) begin
                s_d.status[ST_IDLE] = 1'b1;
                s_d.idle_arm = 1'b0;
              end
            end
          end
          RX_START: begin
            if ((snum == SMP_EDGE1 || snum == SMP_EDGE2 ||
                 snum == SMP_EDGE3) && rxd) begin
              s_d.rx_noise = 1'b1;
            end
            if (snum == SMP_MID3) begin
              if (rxd || s_q.rx_smp[1:0] != 2'b00) begin
                s_d.rx_noise = 1'b1;
              end
              // false start: drop frame, keep noise pending
              if (bitv) s_d.rx_st = RX_IDLE;
            end
            if (s_q.rx_ph == PH_LAST - 4'h1) s_d.rx_st = RX_DATA;
          end
          RX_DATA: begin
            if (snum == SMP_MID3) begin
              if ({rxd, s_q.rx_smp[1:0]} != 3'b000 &&
                  {rxd, s_q.rx_smp[1:0]} != 3'b111) begin
                s_d.rx_noise = 1'b1;
              end
              s_d.rx_sh = {bitv, s_q.rx_sh[8:1]};
              s_d.rx_bit = s_q.rx_bit + 4'h1;
            end
            if (s_q.rx_ph == PH_LAST - 4'h1 &&
                s_q.rx_bit == (s_q.rx_m ? BITS_LONG : BITS_SHORT)) begin
              s_d.rx_st = RX_STOP;
            end
          end
          RX_STOP: begin
            if (snum == SMP_MID3) begin
              if ({rxd, s_q.rx_smp[1:0]} != 3'b111 &&
                  {rxd, s_q.rx_smp[1:0]} != 3'b000) begin
                s_d.rx_noise = 1'b1;
              end
              // frame ends at the stop bit's vote
              s_d.rx_st = RX_IDLE;
              s_d.rx_hist = 3'b111;
              s_d.idle_cnt = 8'h00;
              word = s_q.rx_m ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};
              msb = s_q.rx_m ? word[8] : word[7];
              if (s_q.ctl2[C2_RWU] && s_q.ctl1[C1_WAKE] && msb && !wr2) begin
                s_d.ctl2[C2_RWU] = 1'b0;
              end
              if (!s_q.ctl2[C2_RWU] || (s_q.ctl1[C1_WAKE] && msb)) begin
                s_d.rx_noise = 1'b0;
                s_d.idle_arm = 1'b1;
                if (s_q.status[ST_RX_DATA_READY]) begin
                  s_d.status[ST_OR] = 1'b1; // data kept, frame lost
                end else begin
                  s_d.rdr = word[7:0];
                  s_d.ctl1[C1_R8] = word[8];
                  s_d.status[ST_RX_DATA_READY] = 1'b1;
                  s_d.status[ST_NF] = s_q.status[ST_NF] |
                                      s_q.rx_noise | s_d.rx_noise;
                  s_d.status[ST_FE] = s_q.status[ST_FE] | ~bitv;
                  if (s_q.rx_pce &&
                      ((low_xor(word, s_q.rx_m) ^ msb) != s_q.rx_ps)) begin
                    s_d.status[ST_PE] = 1'b1;
                  end
                end
              end
              // muted non-address frames leave no flag or data, but their noise stays pending in rx_noise
            end
          end
          default: s_d.rx_st = RX_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------
  // state register
  // --------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.status <= RST_STATUS;
      s_q.tx_sh <= 12'hFFF;
      s_q.rx_st <= RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : abmp_serial

// [testbench/abmp_serial_sva.sv]
// checker for the serial block: bus answer, line timing and halt freeze
// assumes a bind onto abmp_serial, one clock pclk, reset presetn
`timescale 1ns/1ps
module abmp_serial_chk
  import abmp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt_mode,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq_req
);
  // --------
  // helper state
  // --------
  typedef struct packed {
    logic       txd; // line level one cycle ago
    logic [7:0] run; // cycles the line has held, saturating
  } abmp_chk_t;
  abmp_chk_t   st_q;   // registered helper state
  abmp_chk_t   st_d;   // next helper state
  logic        acc;    // apb access phase
  logic        mapped; // address hits a register
  assign acc    = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_RX_FINE);
  // restart the hold count whenever the line changes
  always_comb begin
    st_d.txd = txd;
    st_d.run = (txd != st_q.txd) ? 8'h00 : st_q.run + {7'h00, st_q.run != 8'hFF};
  end
  // register the helper state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st_q <= '{txd: 1'b1, run: 8'hFF};
    else
      st_q <= st_d;
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  chk_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_unmapped_read: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_bit_hold: assert property (txd != st_q.txd |-> st_q.run >= 8'h0F)
    else $error("line bit shorter than sixteen clocks");
  chk_start_low: assert property ($fell(txd) |-> (!txd)[*8] ##1 (!txd)[*8])
    else $error("start bit too short");
  chk_halt_line: assert property ($past(halt_mode) |-> $stable(txd))
    else $error("line moved in halt");
  chk_halt_irq: assert property ($past(halt_mode) |-> $stable(irq_req))
    else $error("interrupt moved in halt");
  cov_unmapped: cover property (acc && pslverr);
  cov_frame: cover property ($fell(txd));
  cov_halt_end: cover property ($past(halt_mode) && !halt_mode);
endmodule : abmp_serial_chk

// [testbench/abmp_far_node.sv]
// remote serial node: sends frames on rxd, captures frames from txd
// assumes one bit lasts a whole number of pclk cycles
`timescale 1ns/1ps
module abmp_far_node (
  input  wire logic pclk, // system clock
  input  wire logic txd,  // line from the block
  output logic      rxd   // line into the block, idle high
);
  initial rxd = 1'b1;
  // start, nb data bits lsb first, stop; bit g (-1 = start) gets a one-cycle glitch,
  // a g outside -1..nb means a clean frame
  task automatic send(input logic [8:0] v, input int nb, input int bc, input int g);
    logic b;
    for (int i = -1; i <= nb; i++) begin
      b = (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : v[i];
      @(posedge pclk);
      rxd <= b;
      if (i == g) begin
        repeat (8) @(posedge pclk);
        rxd <= ~b;
        @(posedge pclk);
        rxd <= b;
        repeat (bc - 10) @(posedge pclk);
      end else
        repeat (bc - 1) @(posedge pclk);
    end
  endtask : send
  // wait for a start edge, then sample nb data bits and the stop mid-bit
  task automatic recv(output logic [9:0] w, input int nb, input int bc);
    w = '0;
    do @(posedge pclk); while (txd !== 1'b0);
    repeat (bc / 2) @(posedge pclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bc) @(posedge pclk);
      w[i] = txd;
    end
  endtask : recv
endmodule : abmp_far_node

// [testbench/test_async_serial_baud_mute_parity.sv]
// bench for the serial block: apb tasks, remote node, frame checks
// assumes abmp_pkg, abmp_serial, the node and the checker compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %0t: got %h want %h", $time, g, e); end end
module test_async_serial_baud_mute_parity
  import abmp_pkg::*;
;
  logic        pclk = 1'b0;    // system clock
  logic        presetn = 1'b0; // reset, active low
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        halt_mode = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        irq_req;
  logic [9:0]  w;              // frame seen by the remote node
  int          n_errors = 0;
  int          total_checks = 0;
  logic [7:0]  ctl [4] = '{8'h04, 8'h06, 8'h50, 8'h16};
  logic [9:0]  xfr [4] = '{10'h135, 10'h1B5, 10'h3B5, 10'h2B5};
  always #12.5 pclk = ~pclk;
  abmp_serial uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_mode(halt_mode), .rxd(rxd), .txd(txd), .irq_req(irq_req));
  abmp_far_node far (.pclk(pclk), .txd(txd), .rxd(rxd));
  // --------
  // tasks
  // --------
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // read and compare; an address past the map must answer with an error
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK({e, r}, {a > OFS_RX_FINE, 24'h0, x})
  endtask : rd
  // --------
  // scenarios
  // --------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h1C, 8'h00);
    // idle wake: no further control_two write until woken
    wr(OFS_CTL2, 8'h0E);
    repeat (200) @(posedge pclk);
    rd(OFS_CTL2, 8'h0C);
    rd(OFS_STATUS, 8'hC0);
    // parity and word length on transmit
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTL1, ctl[i]);
      fork
        far.recv(w, ctl[i][C1_M] ? 9 : 8, 16);
        wr(OFS_DATA, 8'hB5);
      join
      `CHK(w, xfr[i])
    end
    // slower transmit rate, changed only while disabled
    wr(OFS_CTL2, 8'h00);
    wr(OFS_RATE, 8'h48);
    wr(OFS_TX_FINE, 8'h02);
    wr(OFS_CTL2, 8'h0C);
    wr(OFS_CTL1, 8'h00);
    fork
      far.recv(w, 8, 192);
      wr(OFS_DATA, 8'hC3);
    join
    `CHK(w, 10'h1C3)
    // let the stop bit end, then back to the base rate while disabled
    repeat (120) @(posedge pclk);
    wr(OFS_CTL2, 8'h00);
    wr(OFS_RATE, 8'h00);
    wr(OFS_TX_FINE, 8'h00);
    wr(OFS_CTL2, 8'h0C);
    // receive at the base rate, even parity, interrupt on error
    wr(OFS_CTL1, 8'h05);
    far.send(9'h035, 8, 16, 15);
    rd(OFS_STATUS, 8'hE0);
    rd(OFS_DATA, 8'h35);
    far.send(9'h0B5, 8, 16, 15);
    `CHK(irq_req, 1'b1)
    rd(OFS_STATUS, 8'hE1);
    rd(OFS_DATA, 8'hB5);
    // the flag clear lands at the access edge, so look one edge later
    @(posedge pclk);
    `CHK(irq_req, 1'b0)
    far.send(9'h035, 8, 16, 2);
    rd(OFS_STATUS, 8'hE4);
    rd(OFS_DATA, 8'h35);
    // glitch on start sample 9 only: frame kept, noise reported
    far.send(9'h035, 8, 16, -1);
    rd(OFS_STATUS, 8'hE4);
    rd(OFS_DATA, 8'h35);
    // address-mark wake; control_two left alone while muted
    wr(OFS_CTL1, 8'h08);
    wr(OFS_CTL2, 8'h0E);
    far.send(9'h012, 8, 16, 15);
    repeat (170) @(posedge pclk);
    rd(OFS_STATUS, 8'hC0);
    rd(OFS_CTL2, 8'h0E);
    far.send(9'h092, 8, 16, 15);
    rd(OFS_STATUS, 8'hE0);
    rd(OFS_CTL2, 8'h0C);
    rd(OFS_DATA, 8'h92);
    // halt: write ignored, line stays idle afterwards
    halt_mode <= 1'b1;
    wr(OFS_DATA, 8'h55);
    rd(OFS_CTL2, 8'h0C);
    repeat (40) @(posedge pclk);
    halt_mode <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK(txd, 1'b1)
    stop_test();
  end
  // watchdog against a hung wait
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
endmodule : test_async_serial_baud_mute_parity
bind abmp_serial abmp_serial_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode), .rxd(rxd), .txd(txd),
  .irq_req(irq_req));
